/* File: common/htc_pkg.sv */
// constants and types shared by the timer/counter design
// Operation
// RULE1 - a sixteen bit counter counting up or down, with compare and pwm
// RULE2 - four modes: watchdog, clear on compare match, fast pwm, phase-frequency pwm
// RULE3 - count clock source is selectable and passes a programmable prescaler
// RULE4 - the compare output pin carries a waveform from the compare logic
// RULE5 - pwm output is glitch free, period variable, count reloads each period
// RULE6 - three interrupt sources: overflow, compare match, input capture
// RULE7 - one static interrupt output goes to the logic fabric
// RULE8 - a separate wake-up interrupt goes to the standby controller
// RULE9 - capture stores the count on a synchronised rising trigger edge, non-pwm modes; here only with the bus interface
// RULE10 - without the bus interface the interrupt output is the overflow flag
// RULE11 - with the bus interface three request bits govern the interrupt output
// RULE12 - control and status are reached by user logic; here as plain ports
// RULE13 - stand-alone mode uses preloaded controls and the direct reset pin
// RULE14 - a preloaded reset-pin enable keeps the active-low reset input enabled
// RULE15 - the capture trigger passes two flip-flops before edge detection
// RULE16 - reset clears count, capture register and all pending flags; here the reset pin keeps the capture register
package htc_pkg;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned PRE_W      = 3;
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam logic [15:0] CAP_RST    = 16'h0000;
  localparam logic [9:0]  PRE_RST    = 10'h000;
  localparam logic [2:0]  FLAG_RST   = 3'h0;
  localparam int unsigned IRQ_OVF    = 0;
  localparam int unsigned IRQ_CMP    = 1;
  localparam int unsigned IRQ_CAP    = 2;

  typedef enum logic [1:0] {
    HTC_WDOG = 2'b00,
    HTC_CTC  = 2'b01,
    HTC_FPWM = 2'b10,
    HTC_PFC  = 2'b11
  } htc_mode_e;
endpackage

/* File: logic/htc_prescale.sv */
// programmable prescaler producing one-cycle count enables
`timescale 1ns/1ps
module htc_prescale (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // control
  input  wire logic       tick_i,
  input  wire logic [2:0] sel_i,
  // enable out
  output logic            en_o
);
  logic [9:0] div_r;
  logic [9:0] div_nxt;

  // divide-by code to terminal mask: 0 stop,1..7 = 1,8,32,64,256,1024,passthru
  function automatic logic [9:0] lim(input logic [2:0] s);
    case (s)
      3'h1:    lim = 10'h000;
      3'h2:    lim = 10'h007;
      3'h3:    lim = 10'h01F;
      3'h4:    lim = 10'h03F;
      3'h5:    lim = 10'h0FF;
      3'h6:    lim = 10'h3FF;
      default: lim = 10'h000;
    endcase
  endfunction

  // next divider value
  always_comb begin
    div_nxt = div_r;
    if (tick_i && sel_i != 3'h0) begin
      div_nxt = (div_r >= lim(sel_i)) ? htc_pkg::PRE_RST : div_r + 10'h001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= htc_pkg::PRE_RST;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign en_o = tick_i && sel_i != 3'h0 && div_r >= lim(sel_i); // see RULE3
endmodule // htc_prescale

/* File: logic/htc_timer.sv */
// sixteen bit timer/counter with compare, capture, pwm and interrupts
`timescale 1ns/1ps
module htc_timer (
  // clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        RESET_N_I,
  // pins
  input  wire logic        COUNT_CLOCK_IN_I,
  input  wire logic        COUNTER_RESET_N_I,
  input  wire logic        CAPTURE_TRIGGER_IN_I,
  output logic             TIMER_IRQ_OUT_O,
  output logic             WAKE_IRQ_O,
  output logic             COMPARE_WAVE_OUT_O,
  // configuration
  input  wire logic        BUS_MODE_I,
  input  wire logic        RESET_PIN_ENABLE_I,
  input  wire logic        CLK_SRC_SEL_I,
  input  wire logic [2:0]  PRESCALE_SEL_I,
  input  wire logic [1:0]  MODE_I,
  input  wire logic        CAPTURE_EN_I,
  input  wire logic [15:0] TOP_I,
  input  wire logic [15:0] COMPARE_I,
  input  wire logic [2:0]  IRQ_EN_I,
  input  wire logic [2:0]  IRQ_CLR_I,
  input  wire logic        WAKE_EN_I,
  // status
  output logic [15:0]      COUNT_VALUE_O,
  output logic [15:0]      CAPTURE_HOLDING_REG_O,
  output logic [2:0]       IRQ_FLAGS_O,
  output logic             COUNT_DOWN_O
);
  localparam int unsigned W = htc_pkg::CNT_W;

  // input synchronisers: two flops each
  logic [2:0] s1_r, s2_r, s3_r;
  logic [2:0] s1_nxt, s3_nxt;
  logic       ext_tick, cap_rise, tick, en, rst_req;
  logic       pre_rst_n;

  always_comb begin
    s1_nxt = {CAPTURE_TRIGGER_IN_I, COUNTER_RESET_N_I, COUNT_CLOCK_IN_I};
    s3_nxt = s2_r;
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s1_r <= 3'h2;
      s2_r <= 3'h2;
      s3_r <= 3'h2;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s1_r;
      s3_r <= s3_nxt;
    end
  end

  assign ext_tick = s2_r[0] && !s3_r[0];                    // rising count clock
  assign cap_rise = s2_r[2] && !s3_r[2];                    // see RULE15
  assign tick     = CLK_SRC_SEL_I ? ext_tick : 1'b1;        // see RULE3
  // reset pin acts when enabled, always in stand-alone mode
  assign rst_req  = !s2_r[1] && (RESET_PIN_ENABLE_I || !BUS_MODE_I); // see RULE13 see RULE14
  assign pre_rst_n = RESET_N_I;

  htc_prescale u_pre (
    .clk_i   (CLOCK_I),
    .rst_n_i (pre_rst_n),
    .tick_i  (tick),
    .sel_i   (PRESCALE_SEL_I),
    .en_o    (en)
  );

  // counter, direction, wave, capture, flags
  logic [W-1:0] cnt_r, cnt_nxt, cap_r, cap_nxt, cmp_r, cmp_nxt;
  logic         dn_r, dn_nxt, wave_r, wave_nxt, wake_r, wake_nxt;
  logic [2:0]   flg_r, flg_nxt, ev;
  logic         at_top, at_cmp, pwm;

  assign pwm    = MODE_I[1];
  assign at_top = cnt_r == TOP_I;
  assign at_cmp = cnt_r == cmp_r;

  always_comb begin
    cnt_nxt  = cnt_r;
    dn_nxt   = dn_r;
    wave_nxt = wave_r;
    cmp_nxt  = cmp_r;
    cap_nxt  = cap_r;
    ev       = 3'h0;
    if (en) begin
      unique case (htc_pkg::htc_mode_e'(MODE_I))
        htc_pkg::HTC_WDOG: begin
          cnt_nxt = cnt_r + 16'h0001;                           // see RULE1
          if (cnt_r == 16'hFFFF) ev[htc_pkg::IRQ_OVF] = 1'b1;
          if (at_cmp) ev[htc_pkg::IRQ_CMP] = 1'b1;
        end
        htc_pkg::HTC_CTC: begin
          cnt_nxt = at_cmp ? 16'h0000 : cnt_r + 16'h0001;       // see RULE2
          if (at_cmp) begin
            ev[htc_pkg::IRQ_CMP] = 1'b1;
            wave_nxt = !wave_r;                                 // see RULE4
          end
          if (cnt_r == 16'hFFFF) ev[htc_pkg::IRQ_OVF] = 1'b1;
        end
        htc_pkg::HTC_FPWM: begin
          cnt_nxt = at_top ? 16'h0000 : cnt_r + 16'h0001;       // see RULE5
          if (at_top) begin
            ev[htc_pkg::IRQ_OVF] = 1'b1;
            cmp_nxt  = COMPARE_I;                               // see RULE5
            wave_nxt = COMPARE_I != 16'h0000;
          end else if (at_cmp) begin
            ev[htc_pkg::IRQ_CMP] = 1'b1;
            wave_nxt = 1'b0;                                    // see RULE4
          end
        end
        htc_pkg::HTC_PFC: begin
          // up to top, down to zero; compare reloaded at bottom
          if (!dn_r) begin
            cnt_nxt = at_top ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
            dn_nxt  = at_top;                                   // see RULE1
          end else begin
            cnt_nxt = (cnt_r == 16'h0000) ? 16'h0001 : cnt_r - 16'h0001;
            dn_nxt  = cnt_r != 16'h0000;
          end
          if (dn_r && cnt_r == 16'h0000) begin
            ev[htc_pkg::IRQ_OVF] = 1'b1;
            cmp_nxt = COMPARE_I;                                // see RULE5
          end
          if (at_cmp) begin
            ev[htc_pkg::IRQ_CMP] = 1'b1;
            wave_nxt = dn_r;                                    // see RULE4
          end
        end
      endcase
    end
    if (!pwm) begin
      cmp_nxt = COMPARE_I;
      if (CAPTURE_EN_I && BUS_MODE_I && cap_rise) begin
        cap_nxt = cnt_r;                                        // see RULE9
        ev[htc_pkg::IRQ_CAP] = 1'b1;
      end
    end
    if (rst_req) begin
      cnt_nxt  = htc_pkg::CNT_RST;
      dn_nxt   = 1'b0;
      wave_nxt = 1'b0;
    end
  end

  // sticky flags; a new event wins over a clear
  always_comb begin
    flg_nxt  = (flg_r & ~IRQ_CLR_I) | ev;                       // see RULE6
    wake_nxt = WAKE_EN_I && |(flg_nxt & IRQ_EN_I);              // see RULE8
    if (rst_req) begin
      flg_nxt  = htc_pkg::FLAG_RST;                             // see RULE16
      wake_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cnt_r  <= htc_pkg::CNT_RST;                               // see RULE16
      cap_r  <= htc_pkg::CAP_RST;
      cmp_r  <= 16'h0000;
      dn_r   <= 1'b0;
      wave_r <= 1'b0;
      flg_r  <= htc_pkg::FLAG_RST;
      wake_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      cap_r  <= cap_nxt;
      cmp_r  <= cmp_nxt;
      dn_r   <= dn_nxt;
      wave_r <= wave_nxt;
      flg_r  <= flg_nxt;
      wake_r <= wake_nxt;
    end
  end

  // interrupt output: overflow flag alone, or masked request bits
  logic irq_r, irq_nxt;
  always_comb begin
    irq_nxt = BUS_MODE_I ? |(flg_nxt & IRQ_EN_I)              // see RULE11
                         : flg_nxt[htc_pkg::IRQ_OVF];          // see RULE10
  end
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign TIMER_IRQ_OUT_O       = irq_r;                         // see RULE7
  assign WAKE_IRQ_O            = wake_r;
  assign COMPARE_WAVE_OUT_O    = wave_r;
  assign COUNT_VALUE_O         = cnt_r;                         // see RULE12
  assign CAPTURE_HOLDING_REG_O = cap_r;
  assign IRQ_FLAGS_O           = flg_r;
  assign COUNT_DOWN_O          = dn_r;

  // checks
  a_cap_store: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I) // see RULE9
    (!pwm && CAPTURE_EN_I && BUS_MODE_I && cap_rise && !rst_req)
      |=> CAPTURE_HOLDING_REG_O == $past(cnt_r))
    else $error("capture register missed the count");
  a_sync_edge: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I) // see RULE15
    cap_rise |-> $past(CAPTURE_TRIGGER_IN_I, 2) && !$past(CAPTURE_TRIGGER_IN_I, 3))
    else $error("capture edge not from synchronised trigger");
  a_flag_sticky: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I) // see RULE6
    (flg_r[0] && !IRQ_CLR_I[0] && !rst_req) |=> IRQ_FLAGS_O[0])
    else $error("overflow flag dropped without clear");
  a_irq_bus: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I) // see RULE11
    BUS_MODE_I |=> TIMER_IRQ_OUT_O == |(IRQ_FLAGS_O & $past(IRQ_EN_I)))
    else $error("interrupt not governed by request bits");
  a_irq_alone: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I) // see RULE10
    !BUS_MODE_I |=> TIMER_IRQ_OUT_O == IRQ_FLAGS_O[0])
    else $error("interrupt not the overflow flag");
  a_pin_reset: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I) // see RULE14
    rst_req |=> COUNT_VALUE_O == 16'h0000 && IRQ_FLAGS_O == 3'h0)
    else $error("reset pin did not clear state");
  a_fpwm_wrap: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I) // see RULE5
    (en && MODE_I == 2'b10 && at_top && !rst_req) |=> COUNT_VALUE_O == 16'h0000)
    else $error("fast pwm did not reload");
  a_ctc_toggle: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I) // see RULE4
    (en && MODE_I == 2'b01 && at_cmp && !rst_req) |=> COMPARE_WAVE_OUT_O != $past(wave_r))
    else $error("compare output did not toggle");
  a_pfc_turn: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I) // see RULE1
    (en && MODE_I == 2'b11 && at_top && !dn_r && !rst_req) |=> COUNT_DOWN_O)
    else $error("counter did not turn down at top");
endmodule // htc_timer

/* File: test/hard_timer_counter_pwm_tb_top.sv */
// self-checking bench for the timer/counter
`timescale 1ns/1ps
module hard_timer_counter_pwm_tb_top;
  logic clk, rst_n, cclk, prst_n, trig, bmode, pen, src, cen, wen, go, irq, wake, wave, down, busy;
  logic [2:0] psel, ien, iclr, flags;
  logic [1:0] mode;
  logic [15:0] top, cmp, cnt, cap;
  logic [7:0] npul;
  logic pw;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int m, h, dv;
  int divs[7] = '{1, 8, 32, 64, 256, 1024, 1};
  htc_timer dut (.CLOCK_I(clk), .RESET_N_I(rst_n), .COUNT_CLOCK_IN_I(cclk),
    .COUNTER_RESET_N_I(prst_n), .CAPTURE_TRIGGER_IN_I(trig), .TIMER_IRQ_OUT_O(irq),
    .WAKE_IRQ_O(wake), .COMPARE_WAVE_OUT_O(wave), .BUS_MODE_I(bmode),
    .RESET_PIN_ENABLE_I(pen), .CLK_SRC_SEL_I(src), .PRESCALE_SEL_I(psel), .MODE_I(mode),
    .CAPTURE_EN_I(cen), .TOP_I(top), .COMPARE_I(cmp), .IRQ_EN_I(ien), .IRQ_CLR_I(iclr),
    .WAKE_EN_I(wen), .COUNT_VALUE_O(cnt), .CAPTURE_HOLDING_REG_O(cap), .IRQ_FLAGS_O(flags),
    .COUNT_DOWN_O(down));
  htc_pin_model u_pins (.clk_i(clk), .go_i(go), .pulses_i(npul), .count_clk_o(cclk),
    .busy_o(busy));
  // clock and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic close_out();
    $display("fails %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi, input logic [15:0] g);
    checks_done++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_fail++;
      $display("unexpected %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // pin reset pulse, then four cycles for the synchronised reset to act
  task automatic pin_rst();
    prst_n = 1'b0;
    step(1);
    prst_n = 1'b1;
    step(4);
  endtask
  task automatic burst(input logic [7:0] n);
    npul = n;
    go = 1'b1;
    step(1);
    go = 1'b0;
    for (int i = 0; i < 400 && busy; i++) step(1);
    step(4);
  endtask
  task automatic t_ctc();
    mode = 2'h1; cmp = 16'h0002; psel = 3'h1; ien = 3'h2; bmode = 1'b1; m = 0; h = 0;
    step(12);
    pw = wave;
    for (int i = 0; i < 12; i++) begin
      if (cnt > m) m = cnt;
      if (wave !== pw) h++;
      pw = wave;
      step(1);
    end
    chk("ctc top", 16'h0002, m[15:0]);
    rng("ctc toggles", 3, 4, h[15:0]);
    chk("cmp flag", 1, flags[1]);
    chk("cmp irq", 1, irq);
    psel = 3'h0; ien = 3'h0;
    step(2);
    chk("masked irq", 0, irq);
    iclr = 3'h7;
    step(2);
    iclr = 3'h0;
    chk("cleared flags", 0, flags);
  endtask
  task automatic t_pre();
    mode = 2'h0; src = 1'b0;
    for (int s = 1; s < 8; s++) begin
      pin_rst();
      psel = s[2:0];
      step(divs[s-1] * 10);
      psel = 3'h0;
      step(3);
      rng("prescaled count", 9, 11, cnt);
    end
  endtask
  task automatic t_cap();
    pin_rst(); src = 1'b1; psel = 3'h1; cen = 1'b1; bmode = 1'b1; mode = 2'h0;
    burst(8'd5);
    chk("ext count", 16'h0005, cnt);
    trig = 1'b1;
    step(5);
    trig = 1'b0;
    chk("capture", 16'h0005, cap);
    chk("cap flag", 1, flags[2]);
    bmode = 1'b0;
    burst(8'd3);
    trig = 1'b1;
    step(5);
    trig = 1'b0;
    chk("refused capture", 16'h0005, cap);
    bmode = 1'b1; pen = 1'b0; psel = 3'h0;
    pin_rst();
    chk("pin ignored", 16'h0008, cnt);
    bmode = 1'b0;
    pin_rst();
    chk("pin count", 16'h0000, cnt);
    chk("pin keeps cap", 16'h0005, cap);
    src = 1'b0; pen = 1'b1;
  endtask
  task automatic t_pwm(input logic [1:0] md);
    mode = md; top = 16'h0009; cmp = 16'h0003; psel = 3'h1; m = 0; h = 0; dv = 0;
    step(30);
    for (int i = 0; i < 40; i++) begin
      if (cnt > m) m = cnt;
      if (wave === 1'b1) h++;
      if (down === 1'b1) dv++;
      step(1);
    end
    chk("pwm top", 16'h0009, m[15:0]);
    // four of ten counts high in fast pwm; six of eighteen in phase-frequency pwm
    if (md == 2'h2) begin
      chk("fpwm high", 16'h0010, h[15:0]);
    end else begin
      rng("pfc down", 18, 22, dv[15:0]);
      rng("pfc high", 12, 16, h[15:0]);
    end
  endtask
  task automatic t_ovf();
    mode = 2'h0; psel = 3'h0; ien = 3'h1; wen = 1'b1;
    pin_rst();
    psel = 3'h1;
    for (int i = 0; i < 66000 && flags[0] !== 1'b1; i++) step(1);
    step(1);
    chk("ovf flag", 1, flags[0]);
    chk("ovf irq", 1, irq);
    chk("wake", 1, wake);
    rng("wrapped", 0, 4, cnt);
  endtask
  initial begin
    clk = 0; rst_n = 0; prst_n = 1; trig = 0; bmode = 1; pen = 1; src = 0; cen = 0;
    wen = 0; go = 0; psel = 0; ien = 0; iclr = 0; mode = 0; top = 0; cmp = 0; npul = 0;
    step(6);
    rst_n = 1'b1;
    step(1);
    chk("reset count", 16'h0000, cnt);
    chk("reset cap", 16'h0000, cap);
    chk("reset flags", 16'h0000, flags);
    chk("reset irq", 0, irq);
    t_ctc();
    t_pre();
    t_cap();
    t_pwm(2'h2);
    t_pwm(2'h3);
    t_ovf();
    close_out();
  end
endmodule // hard_timer_counter_pwm_tb_top

/* File: test/htc_pin_model.sv */
// pin-side model: bursts of slow count clock pulses
`timescale 1ns/1ps
module htc_pin_model (
  // clock
  input  wire logic       clk_i,
  // request
  input  wire logic       go_i,
  input  wire logic [7:0] pulses_i,
  // pin and status
  output logic            count_clk_o,
  output logic            busy_o
);
  logic [8:0] left_r;
  logic [1:0] div_r;
  initial begin
    count_clk_o = 1'b0;
    busy_o = 1'b0;
    left_r = '0;
    div_r = '0;
  end
  // level held four cycles, so the rate stays under a quarter clock; idle low
  always @(posedge clk_i) begin
    if (go_i && left_r == 0) begin
      left_r <= {pulses_i, 1'b0};
    end else if (left_r != 0) begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3) begin
        count_clk_o <= ~count_clk_o;
        left_r <= left_r - 9'h001;
      end
    end
    busy_o <= go_i || (left_r != 0);
  end
endmodule // htc_pin_model
